// file: rtl/rxls_top.sv
// Decided for this implementation: the AHB-Lite slave port.
`timescale 1ns/1ps
module rxls_top #(
  parameter int FRAME_CYCLES = rxls_pkg::FRAME_CYCLES,
  parameter int SEC_FRAMES = rxls_pkg::SEC_FRAMES
) (
  input wire logic hclk, // Bus and block clock.
  input wire logic hresetn, // Asynchronous reset, active low.
  input wire logic hsel, // Slave select.
  input wire logic [31:0] haddr, // Byte address.
  input wire logic [1:0] htrans, // Transfer type.
  input wire logic hwrite, // Write when high.
  input wire logic [2:0] hsize, // Transfer size, word only.
  input wire logic [31:0] hwdata, // Write data.
  input wire logic hready, // Bus ready.
  output logic hreadyout, // Slave ready.
  output logic hresp, // Always OKAY.
  output logic [31:0] hrdata, // Read data.
  input wire logic rx_clk_pin, // Recovered receive clock, watched for activity.
  input wire rxls_pkg::rxls_frm_t frm, // Framer conditions on hclk.
  input wire rxls_pkg::rxls_hdlc_t hdlc, // HDLC receiver conditions on hclk.
  output logic hdlc_stop, // Pulse ending packet reception on overrun.
  output logic irq // Level, any unmasked latched bit; of the second register only bits 3:0, and only in E1.
);
  rxls_pkg::rxls_state_t st;
  rxls_pkg::rxls_state_t nx;
  logic acc;
  logic [9:0] aidx;
  logic e1;
  logic [7:0] set2;
  logic [7:0] set3;
  logic [7:0] set4;
  logic [7:0] set5;
  logic [3:0] cond;
  logic [9:0] loss_lim;
  logic arb_mf;
  logic sec_tick;
  logic upd_tick;
  logic manual;
  logic above;
  logic [7:0] zsum;
  logic [3:0] info;

  assign acc = hsel && htrans[1] && hready;
  assign aidx = haddr[11:2];
  assign e1 = st.cfg[rxls_pkg::CFG_E1];

  // Summary bits per status register, masked before use.
  assign info[0] = |(st.stat_two & st.mask[7:0] & (e1 ? rxls_pkg::S2_E1_INT_BITS : 8'h00));
  assign info[1] = |(st.stat_three & st.mask[15:8]);
  assign info[2] = |(st.stat_four & st.mask[23:16]);
  assign info[3] = |(st.stat_hdlc & st.mask[31:24]);

  always_comb begin
    nx = st;
    set2 = 8'h00;
    set3 = 8'h00;
    set4 = 8'h00;
    set5 = 8'h00;
    manual = 1'b0;
    arb_mf = 1'b0;
    sec_tick = 1'b0;
    upd_tick = 1'b0;
    zsum = 8'h00;
    nx.rdy = 1'b1;
    nx.hdlc_stop = 1'b0;
    nx.frame_en = 1'b0;

    // Frame-rate enable; all slower timers count frames divided down from hclk.
    if (st.frm_div == 16'(FRAME_CYCLES - 1)) begin
      nx.frm_div = 16'h0000;
      nx.frame_en = 1'b1;
    end else begin
      nx.frm_div = st.frm_div + 16'h0001;
    end
    if (st.frame_en) begin
      nx.align_ph = (st.align_ph == 1'(rxls_pkg::ALIGN_FRAMES - 1)) ? 1'b0 : 1'b1;
      nx.mf16_cnt = st.mf16_cnt + 4'h1;
      arb_mf = st.mf16_cnt == 4'(rxls_pkg::MF_ARB_FRAMES - 1);
      sec_tick = st.sec_cnt == 16'(SEC_FRAMES - 1);
      nx.sec_cnt = sec_tick ? 16'h0000 : st.sec_cnt + 16'h0001;
      // A count left above the limit by a mode change wraps at once, not after 1024 frames.
      if (st.upd_cnt >= (e1 ? 10'(rxls_pkg::UPD_E1_FRAMES - 1)
                            : 10'(rxls_pkg::UPD_T1_FRAMES - 1))) begin
        nx.upd_cnt = 10'h000;
        upd_tick = st.cfg[rxls_pkg::CFG_SHORT];
      end else begin
        nx.upd_cnt = st.upd_cnt + 10'h001;
      end
    end

    // Receive clock activity: sync[0] feeds only sync[1].
    nx.clk_sync = {st.clk_sync[1:0], rx_clk_pin};
    loss_lim = e1 ? 10'(rxls_pkg::CHAN_E1_CYCLES) : 10'(rxls_pkg::CHAN_T1_CYCLES);
    if (st.clk_sync[2] != st.clk_sync[1]) begin
      nx.clk_idle = 10'h000;
    end else if (st.clk_idle != loss_lim) begin
      nx.clk_idle = st.clk_idle + 10'h001;
    end
    nx.clk_loss = st.clk_idle == loss_lim;

    if (!e1) begin
      if (frm.fbit_strobe) begin
        nx.fbit_hist = {st.fbit_hist[4:0], frm.fbit_err};
        set2[rxls_pkg::S2_FBE] = frm.fbit_err;
        set2[rxls_pkg::S2_SEVERE_FRAMING_ERR_EVT] = frm.fbit_err && (st.fbit_hist[4:0] != 5'h00);
      end
      set2[rxls_pkg::S2_B8ZS] = frm.b8zs_codeword;
      set4[rxls_pkg::S4_RMF] = frm.rx_mf_boundary;
    end else begin
      if (frm.crc_word) begin
        nx.crc_errs = st.crc_errs + 10'(frm.crc_word_err);
        set2[rxls_pkg::S2_CRC] = frm.crc_word_err
          && (st.crc_errs == 10'(rxls_pkg::CRC_LIMIT - 1));
        if (st.crc_blk == 10'(rxls_pkg::CRC_BLOCK - 1)) begin
          nx.crc_blk = 10'h000;
          nx.crc_errs = 10'h000;
        end else begin
          nx.crc_blk = st.crc_blk + 10'h001;
        end
      end
      if (frm.cas_word) begin
        nx.cas_run = frm.cas_word_err ? st.cas_run + 2'(st.cas_run != 2'(rxls_pkg::CAS_LIMIT))
                                      : 2'h0;
        set2[rxls_pkg::S2_CAS] = frm.cas_word_err
          && (st.cas_run == 2'(rxls_pkg::CAS_LIMIT - 1));
      end
      if (frm.fas_word) begin
        nx.fas_run = frm.fas_word_err ? st.fas_run + 2'(st.fas_run != 2'(rxls_pkg::FAS_LIMIT))
                                      : 2'h0;
        set2[rxls_pkg::S2_FAS] = frm.fas_word_err
          && (st.fas_run == 2'(rxls_pkg::FAS_LIMIT - 1));
      end
      set2[rxls_pkg::S2_RAF] = st.frame_en && st.align_ph;
      set2[rxls_pkg::S2_CRC_MULTIFRAME_EVT] = st.cfg[rxls_pkg::CFG_CRC4] ? frm.crc_mf_boundary : arb_mf;
      set4[rxls_pkg::S4_RMF] = st.cfg[rxls_pkg::CFG_CAS] ? frm.rx_mf_boundary : arb_mf;
    end

    // Slot 16 is judged per multiframe, frame 0 opening each 16-frame block.
    if (frm.ts16_valid) begin
      zsum = (frm.ts16_frame == 4'h0 ? 8'h00 : st.ts16_zeros)
             + 8'($countones(~frm.ts16_byte));
      nx.ts16_zeros = zsum;
      if (frm.ts16_frame == 4'(rxls_pkg::TS16_FRAMES - 1)) begin
        set2[rxls_pkg::S2_TS16_ALL_ONES_EVT] = e1 && (zsum < 8'(rxls_pkg::TS16_MIN_ZEROS));
        set2[rxls_pkg::S2_TS16_ALL_ZEROS_EVT] = e1 && (zsum == 8'(8 * rxls_pkg::TS16_FRAMES));
      end
      if (frm.ts16_frame == 4'h0) begin
        if (!frm.ts16_byte[rxls_pkg::DMA_BIT]) begin
          nx.dma_run = 2'h0;
        end else if (st.dma_run != 2'(rxls_pkg::DMA_MFS)) begin
          nx.dma_run = st.dma_run + 2'h1;
        end
      end
    end

    // Edge-detected conditions; slot 3 is always clock loss.
    if (e1) begin
      cond = {st.clk_loss, 1'b0, frm.v52_link_ident,
              st.dma_run == 2'(rxls_pkg::DMA_MFS)};
    end else begin
      cond = {st.clk_loss, frm.spare_code_match, frm.loopdown_code_match,
              frm.loopup_code_match};
    end
    nx.cond_prev = cond;
    set3 = {st.cond_prev & ~cond, cond & ~st.cond_prev};

    set4[rxls_pkg::S4_FULL] = frm.estore_full;
    set4[rxls_pkg::S4_EMPTY] = frm.estore_empty;
    set4[rxls_pkg::S4_SLIP] = frm.estore_full || frm.estore_empty;
    set4[rxls_pkg::S4_COS] = |(frm.sig_change & st.sig_enable);
    set4[rxls_pkg::S4_SEC] = sec_tick;

    // HDLC receive side.
    nx.hdlc_stop = hdlc.fifo_full && hdlc.receiving;
    set5[rxls_pkg::S5_OVR] = nx.hdlc_stop;
    set5[rxls_pkg::S5_PS] = hdlc.opening_byte;
    set5[rxls_pkg::S5_OBT] = hdlc.next_is_first;
    set5[rxls_pkg::S5_PE] = hdlc.good_crc || hdlc.crc_err || hdlc.abort_seen
                            || nx.hdlc_stop;
    above = hdlc.fifo_level >= st.hwm;
    nx.hwm_prev = above;
    nx.ne_prev = hdlc.fifo_level != 7'h00;
    set5[rxls_pkg::S5_HWMS] = above && !st.hwm_prev;
    set5[rxls_pkg::S5_NES] = nx.ne_prev && !st.ne_prev;

    // Register writes complete in the data phase.
    if (st.wr_pend) begin
      nx.wr_pend = 1'b0;
      unique case (st.wr_idx)
        rxls_pkg::IDX_CONFIG: begin
          nx.cfg = {hwdata[7:5], 1'b0, hwdata[3:0]};
          manual = hwdata[rxls_pkg::CFG_LATCH];
        end
        rxls_pkg::IDX_SIG_ENABLE: nx.sig_enable = hwdata;
        rxls_pkg::IDX_HDLC_CTRL: nx.hwm = hwdata[6:0];
        rxls_pkg::IDX_INT_MASK: nx.mask = hwdata;
        default: nx.wr_pend = 1'b0;
      endcase
    end
    if (manual) begin
      nx.upd_cnt = 10'h000;
    end
    set4[rxls_pkg::S4_TIMER] = manual || upd_tick
      || (sec_tick && !st.cfg[rxls_pkg::CFG_SHORT]);

    // Latch: a read clears what it returned, but sets of the same edge win.
    nx.stat_two = st.stat_two | set2;
    nx.stat_three = st.stat_three | set3;
    nx.stat_four = st.stat_four | set4;
    nx.stat_hdlc = st.stat_hdlc | set5;
    if (acc && !hwrite) begin
      nx.rdata = 32'h0000_0000;
      unique case (aidx)
        rxls_pkg::IDX_STAT_TWO: begin
          nx.rdata[7:0] = st.stat_two;
          nx.stat_two = set2;
        end
        rxls_pkg::IDX_STAT_THREE: begin
          nx.rdata[7:0] = st.stat_three;
          nx.stat_three = set3;
        end
        rxls_pkg::IDX_STAT_FOUR: begin
          nx.rdata[7:0] = st.stat_four;
          nx.stat_four = set4;
        end
        rxls_pkg::IDX_STAT_HDLC: begin
          nx.rdata[7:0] = st.stat_hdlc;
          nx.stat_hdlc = set5;
        end
        rxls_pkg::IDX_CONFIG: nx.rdata[7:0] = st.cfg;
        rxls_pkg::IDX_SIG_ENABLE: nx.rdata = st.sig_enable;
        rxls_pkg::IDX_HDLC_CTRL: nx.rdata[6:0] = st.hwm;
        rxls_pkg::IDX_INT_MASK: nx.rdata = st.mask;
        rxls_pkg::IDX_INT_INFO: nx.rdata[4:1] = info;
        default: nx.rdata = 32'h0000_0000;
      endcase
    end
    if (acc && hwrite) begin
      nx.wr_pend = 1'b1;
      nx.wr_idx = aidx;
    end
    nx.irq = |info;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st <= rxls_pkg::ST_RST;
    end else begin
      st <= nx;
    end
  end

  assign hreadyout = st.rdy;
  assign hresp = 1'b0 & st.rdy;
  assign hrdata = st.rdata;
  assign hdlc_stop = st.hdlc_stop;
  assign irq = st.irq;

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  rd_data_a: assert property (acc && !hwrite && aidx == rxls_pkg::IDX_STAT_FOUR
    |=> hrdata[7:0] == $past(st.stat_four)) else $error("status read data wrong");
  hold_bit_a: assert property (st.stat_hdlc[rxls_pkg::S5_PE] && !(acc && !hwrite)
    |=> st.stat_hdlc[rxls_pkg::S5_PE]) else $error("latched bit lost");
  severe_framing_err_evt_a: assert property (!e1 && frm.fbit_strobe && frm.fbit_err && st.fbit_hist[4:0] != 5'h00
    |=> st.stat_two[rxls_pkg::S2_SEVERE_FRAMING_ERR_EVT]) else $error("severe framing not latched");
  fbe_a: assert property (!e1 && frm.fbit_strobe && frm.fbit_err
    |=> st.stat_two[rxls_pkg::S2_FBE]) else $error("frame bit error not latched");
  crc_limit_a: assert property (e1 && frm.crc_word && frm.crc_word_err && st.crc_errs == 10'd914
    |=> st.stat_two[rxls_pkg::S2_CRC]) else $error("crc resync not latched");
  fas_run_a: assert property (e1 && frm.fas_word && frm.fas_word_err && st.fas_run == 2'd2
    |=> st.stat_two[rxls_pkg::S2_FAS]) else $error("fas resync not latched");
  clk_loss_a: assert property ($rose(st.clk_loss)
    |=> st.stat_three[3]) else $error("clock loss detect not latched");
  cond_clear_a: assert property ($fell(st.cond_prev[0])
    |-> st.stat_three[4]) else $error("condition clear not latched");
  overrun_a: assert property (hdlc.fifo_full && hdlc.receiving
    |=> hdlc_stop && st.stat_hdlc[rxls_pkg::S5_OVR]) else $error("overrun not handled");
  t1_quiet_a: assert property (!e1 && st.stat_three == 8'h00 && st.stat_four == 8'h00
    && st.stat_hdlc == 8'h00 |=> !irq) else $error("second register interrupted");
  slip_a: assert property (frm.estore_full || frm.estore_empty
    |=> st.stat_four[rxls_pkg::S4_SLIP]) else $error("slip not latched");

  read_clear_c: cover property (acc && !hwrite && aidx == rxls_pkg::IDX_STAT_TWO
    && st.stat_two != 8'h00);
  clk_loss_c: cover property ($rose(st.clk_loss));
  overrun_c: cover property (hdlc_stop);
  set_on_read_c: cover property (acc && !hwrite && aidx == rxls_pkg::IDX_STAT_HDLC
    && set5 != 8'h00);
endmodule

// file: inc/rxls_pkg.sv
package rxls_pkg;
  // Register indices; the byte address on the bus is four times the index.
  localparam logic [9:0] IDX_STAT_TWO = 10'h091;
  localparam logic [9:0] IDX_STAT_THREE = 10'h092;
  localparam logic [9:0] IDX_STAT_FOUR = 10'h093;
  localparam logic [9:0] IDX_STAT_HDLC = 10'h094;
  localparam logic [9:0] IDX_STAT_SEVEN = 10'h096;
  localparam logic [9:0] IDX_CONFIG = 10'h0b0;
  localparam logic [9:0] IDX_SIG_ENABLE = 10'h0b1;
  localparam logic [9:0] IDX_HDLC_CTRL = 10'h0b2;
  localparam logic [9:0] IDX_INT_MASK = 10'h0b3;
  localparam logic [9:0] IDX_INT_INFO = 10'h0b4;
  // Configuration fields.
  localparam int CFG_E1 = 0;
  localparam int CFG_CRC4 = 1;
  localparam int CFG_CAS = 2;
  localparam int CFG_SHORT = 3;
  localparam int CFG_LATCH = 4;
  // Second status register, T1 and E1 layouts.
  localparam int S2_FBE = 0;
  localparam int S2_B8ZS = 1;
  localparam int S2_SEVERE_FRAMING_ERR_EVT = 2;
  localparam int S2_RAF = 0;
  localparam int S2_CRC_MULTIFRAME_EVT = 1;
  localparam int S2_TS16_ALL_ZEROS_EVT = 2;
  localparam int S2_TS16_ALL_ONES_EVT = 3;
  localparam int S2_FAS = 4;
  localparam int S2_CAS = 5;
  localparam int S2_CRC = 6;
  localparam logic [7:0] S2_E1_INT_BITS = 8'h0f;
  // Third status register: condition slot i detects at bit i, clears at bit i+4.
  localparam int S3_CLR_OFS = 4;
  // Fourth status register.
  localparam int S4_RMF = 0;
  localparam int S4_TIMER = 1;
  localparam int S4_SEC = 2;
  localparam int S4_COS = 3;
  localparam int S4_SLIP = 5;
  localparam int S4_EMPTY = 6;
  localparam int S4_FULL = 7;
  // HDLC status register.
  localparam int S5_NES = 0;
  localparam int S5_HWMS = 1;
  localparam int S5_PS = 2;
  localparam int S5_PE = 3;
  localparam int S5_OBT = 4;
  localparam int S5_OVR = 5;
  // Reset values.
  localparam logic [7:0] STAT_RST = 8'h00;
  localparam logic [7:0] CFG_RST = 8'h00;
  localparam logic [31:0] SIG_ENABLE_RST = 32'h0000_0000;
  localparam logic [6:0] HWM_RST = 7'h20;
  localparam logic [31:0] MASK_RST = 32'h0000_0000;
  // Timing.
  localparam int CLK_HZ = 100_000_000;
  localparam int CLK_NS = 10;
  localparam int FRAME_NS = 125_000;
  localparam int FRAME_CYCLES = FRAME_NS / CLK_NS;
  localparam int ALIGN_NS = 250_000;
  localparam int ALIGN_FRAMES = ALIGN_NS / FRAME_NS;
  localparam int MF_ARB_NS = 2_000_000;
  localparam int MF_ARB_FRAMES = MF_ARB_NS / FRAME_NS;
  localparam int SEC_NS = 1_000_000_000;
  localparam int SEC_FRAMES = SEC_NS / FRAME_NS;
  localparam int UPD_T1_NS = 42_000_000;
  localparam int UPD_T1_FRAMES = UPD_T1_NS / FRAME_NS;
  localparam int UPD_E1_NS = 62_500_000;
  localparam int UPD_E1_FRAMES = UPD_E1_NS / FRAME_NS;
  localparam int BITS_PER_CHAN = 8;
  localparam int T1_BIT_HZ = 1_544_000;
  localparam int E1_BIT_HZ = 2_048_000;
  localparam int CHAN_T1_CYCLES = BITS_PER_CHAN * CLK_HZ / T1_BIT_HZ;
  localparam int CHAN_E1_CYCLES = BITS_PER_CHAN * CLK_HZ / E1_BIT_HZ;
  // Detection criteria.
  localparam int SEVERE_FRAMING_ERR_EVT_WINDOW = 6;
  localparam int SEVERE_FRAMING_ERR_EVT_ERRS = 2;
  localparam int CRC_BLOCK = 1000;
  localparam int CRC_LIMIT = 915;
  localparam int CAS_LIMIT = 2;
  localparam int FAS_LIMIT = 3;
  localparam int TS16_FRAMES = 16;
  localparam int TS16_MIN_ZEROS = 3;
  localparam int DMA_BIT = 2;
  localparam int DMA_MFS = 2;

  typedef struct packed {
    logic fbit_strobe;
    logic fbit_err;
    logic b8zs_codeword;
    logic crc_word;
    logic crc_word_err;
    logic cas_word;
    logic cas_word_err;
    logic fas_word;
    logic fas_word_err;
    logic ts16_valid;
    logic [3:0] ts16_frame;
    logic [7:0] ts16_byte;
    logic crc_mf_boundary;
    logic rx_mf_boundary;
    logic estore_full;
    logic estore_empty;
    logic [31:0] sig_change;
    logic spare_code_match;
    logic loopdown_code_match;
    logic loopup_code_match;
    logic v52_link_ident;
  } rxls_frm_t;

  typedef struct packed {
    logic opening_byte;
    logic next_is_first;
    logic good_crc;
    logic crc_err;
    logic abort_seen;
    logic receiving;
    logic fifo_full;
    logic [6:0] fifo_level;
  } rxls_hdlc_t;

  typedef struct packed {
    logic rdy;
    logic [31:0] rdata;
    logic wr_pend;
    logic [9:0] wr_idx;
    logic [7:0] stat_two;
    logic [7:0] stat_three;
    logic [7:0] stat_four;
    logic [7:0] stat_hdlc;
    logic [7:0] cfg;
    logic [31:0] sig_enable;
    logic [6:0] hwm;
    logic [31:0] mask;
    logic irq;
    logic hdlc_stop;
    logic [5:0] fbit_hist;
    logic [9:0] crc_blk;
    logic [9:0] crc_errs;
    logic [1:0] cas_run;
    logic [1:0] fas_run;
    logic [7:0] ts16_zeros;
    logic [1:0] dma_run;
    logic [2:0] clk_sync;
    logic [9:0] clk_idle;
    logic clk_loss;
    logic [3:0] cond_prev;
    logic [15:0] frm_div;
    logic frame_en;
    logic align_ph;
    logic [3:0] mf16_cnt;
    logic [15:0] sec_cnt;
    logic [9:0] upd_cnt;
    logic hwm_prev;
    logic ne_prev;
  } rxls_state_t;

  localparam rxls_state_t ST_RST = '{rdy: 1'b1, stat_two: STAT_RST, stat_three: STAT_RST,
    stat_four: STAT_RST, stat_hdlc: STAT_RST, cfg: CFG_RST, sig_enable: SIG_ENABLE_RST,
    hwm: HWM_RST, mask: MASK_RST, default: '0};
endpackage

// file: verif/rxls_top_test.sv
`timescale 1ns/1ps
module rxls_top_test;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, rx_clk_pin, hdlc_stop, irq, clk_run;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata, rd;
  rxls_pkg::rxls_frm_t frm;
  rxls_pkg::rxls_hdlc_t hdlc;
  int miscompares, tests_run;

  rxls_top #(.FRAME_CYCLES(8), .SEC_FRAMES(20)) uut (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .rx_clk_pin(rx_clk_pin), .frm(frm), .hdlc(hdlc),
    .hdlc_stop(hdlc_stop), .irq(irq));

  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end

  // The receive clock pin toggles unless a test stops it to provoke a loss.
  always @(posedge hclk) begin
    if (!hresetn)
      rx_clk_pin <= 1'b0;
    else if (clk_run)
      rx_clk_pin <= ~rx_clk_pin;
  end

  task automatic give_verdict();
    $display("checks %0d, mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: expected %h, got %h", $time, exp, got);
    end
  endtask

  // A slave that never raises ready ends the run instead of hanging it.
  task automatic wait_ready();
    int n;
    n = 0;
    @(posedge hclk);
    while (hreadyout !== 1'b1) begin
      n++;
      if (n > 50) begin
        miscompares++;
        give_verdict();
      end
      @(posedge hclk);
    end
  endtask

  task automatic bus(input logic wr, input logic [9:0] idx, input logic [31:0] wd);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= wr;
    haddr <= {20'h0, idx, 2'b00};
    wait_ready();
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    wait_ready();
    rd = hrdata;
  endtask

  task automatic pf(input rxls_pkg::rxls_frm_t p);
    @(posedge hclk);
    frm <= frm | p;
    @(posedge hclk);
    frm <= frm & ~p;
  endtask

  task automatic ph(input rxls_pkg::rxls_hdlc_t p);
    @(posedge hclk);
    hdlc <= hdlc | p;
    @(posedge hclk);
    hdlc <= hdlc & ~p;
  endtask

  task automatic test_reset();
    logic [9:0] ids [5];
    ids = '{rxls_pkg::IDX_STAT_TWO, rxls_pkg::IDX_STAT_THREE, rxls_pkg::IDX_STAT_FOUR,
      rxls_pkg::IDX_STAT_HDLC, rxls_pkg::IDX_STAT_SEVEN};
    foreach (ids[i]) begin
      bus(1'b0, ids[i], 32'h0);
      check(32'h0, rd);
    end
    bus(1'b0, rxls_pkg::IDX_HDLC_CTRL, 32'h0);
    check(32'h20, rd);
    bus(1'b1, rxls_pkg::IDX_STAT_HDLC, 32'hff);
    bus(1'b0, rxls_pkg::IDX_STAT_HDLC, 32'h0);
    check(32'h0, rd);
    bus(1'b0, 10'h0c0, 32'h0);
    check(32'h0, rd);
    check(32'h0, 32'(hresp));
    check(32'h1, 32'(hreadyout));
    $display("test reset done");
  endtask

  task automatic test_t1();
    bus(1'b1, rxls_pkg::IDX_INT_MASK, 32'h0000_00ff);
    pf('{fbit_strobe: 1'b1, fbit_err: 1'b1, default: '0});
    repeat (2) @(posedge hclk);
    check(32'h0, 32'(irq));
    bus(1'b0, rxls_pkg::IDX_STAT_TWO, 32'h0);
    check(32'h01, rd);
    repeat (6) pf('{fbit_strobe: 1'b1, default: '0});
    for (int k = 0; k < 2; k++) begin
      pf('{fbit_strobe: 1'b1, fbit_err: 1'b1, default: '0});
      bus(1'b0, rxls_pkg::IDX_STAT_TWO, 32'h0);
      check(k ? 32'h05 : 32'h01, rd);
    end
    pf('{b8zs_codeword: 1'b1, default: '0});
    bus(1'b0, rxls_pkg::IDX_STAT_TWO, 32'h0);
    check(32'h02, rd);
    bus(1'b0, rxls_pkg::IDX_STAT_TWO, 32'h0);
    check(32'h0, rd);
    $display("test t1 framing done");
  endtask

  task automatic test_e1();
    bus(1'b1, rxls_pkg::IDX_CONFIG, 32'h1);
    bus(1'b1, rxls_pkg::IDX_INT_MASK, 32'h0000_00f0);
    bus(1'b0, rxls_pkg::IDX_STAT_THREE, 32'h0);
    repeat (2) pf('{fas_word: 1'b1, fas_word_err: 1'b1, default: '0});
    bus(1'b0, rxls_pkg::IDX_STAT_TWO, 32'h0);
    check(32'h0, rd & 32'h70);
    pf('{fas_word: 1'b1, fas_word_err: 1'b1, default: '0});
    repeat (2) @(posedge hclk);
    check(32'h0, 32'(irq));
    bus(1'b0, rxls_pkg::IDX_STAT_TWO, 32'h0);
    check(32'h10, rd & 32'h70);
    repeat (2) pf('{cas_word: 1'b1, cas_word_err: 1'b1, default: '0});
    bus(1'b0, rxls_pkg::IDX_STAT_TWO, 32'h0);
    check(32'h20, rd & 32'h70);
    for (int b = 0; b < 2; b++) begin
      for (int i = 0; i < 16; i++)
        pf('{ts16_valid: 1'b1, ts16_frame: 4'(i), ts16_byte: b ? 8'h00 : 8'hff, default: '0});
      bus(1'b0, rxls_pkg::IDX_STAT_TWO, 32'h0);
      check(b ? 32'h04 : 32'h08, rd & 32'h0c);
    end
    bus(1'b1, rxls_pkg::IDX_INT_MASK, 32'h0000_0001);
    repeat (40) @(posedge hclk);
    check(32'h1, 32'(irq));
    $display("test e1 resync done");
  endtask

  task automatic test_codes();
    bus(1'b1, rxls_pkg::IDX_CONFIG, 32'h0);
    bus(1'b1, rxls_pkg::IDX_INT_MASK, 32'h0);
    bus(1'b0, rxls_pkg::IDX_STAT_THREE, 32'h0);
    frm.spare_code_match <= 1'b1;
    bus(1'b0, rxls_pkg::IDX_STAT_THREE, 32'h0);
    check(32'h04, rd);
    frm.spare_code_match <= 1'b0;
    bus(1'b0, rxls_pkg::IDX_STAT_THREE, 32'h0);
    check(32'h40, rd);
    clk_run <= 1'b0;
    repeat (700) @(posedge hclk);
    bus(1'b0, rxls_pkg::IDX_STAT_THREE, 32'h0);
    check(32'h08, rd);
    clk_run <= 1'b1;
    repeat (20) @(posedge hclk);
    bus(1'b0, rxls_pkg::IDX_STAT_THREE, 32'h0);
    check(32'h80, rd);
    $display("test codes done");
  endtask

  task automatic test_estore();
    bus(1'b1, rxls_pkg::IDX_INT_MASK, 32'h0080_0000);
    pf('{estore_full: 1'b1, default: '0});
    repeat (2) @(posedge hclk);
    check(32'h1, 32'(irq));
    bus(1'b0, rxls_pkg::IDX_INT_INFO, 32'h0);
    check(32'h08, rd);
    bus(1'b0, rxls_pkg::IDX_STAT_FOUR, 32'h0);
    check(32'ha0, rd & 32'he0);
    repeat (2) @(posedge hclk);
    check(32'h0, 32'(irq));
    pf('{estore_empty: 1'b1, default: '0});
    repeat (2) @(posedge hclk);
    check(32'h0, 32'(irq));
    bus(1'b0, rxls_pkg::IDX_STAT_FOUR, 32'h0);
    check(32'h60, rd & 32'he0);
    bus(1'b1, rxls_pkg::IDX_SIG_ENABLE, 32'h4);
    for (int k = 0; k < 2; k++) begin
      pf('{sig_change: k ? 32'h4 : 32'h1, default: '0});
      bus(1'b0, rxls_pkg::IDX_STAT_FOUR, 32'h0);
      check(k ? 32'h08 : 32'h0, rd & 32'h08);
    end
    $display("test estore done");
  endtask

  task automatic test_hdlc();
    hdlc.receiving <= 1'b1;
    hdlc.fifo_full <= 1'b1;
    @(posedge hclk);
    hdlc.fifo_full <= 1'b0;
    #1 check(32'h1, 32'(hdlc_stop));
    @(posedge hclk);
    #1 check(32'h0, 32'(hdlc_stop));
    bus(1'b0, rxls_pkg::IDX_STAT_HDLC, 32'h0);
    check(32'h20, rd & 32'h20);
    ph('{opening_byte: 1'b1, default: '0});
    ph('{good_crc: 1'b1, default: '0});
    bus(1'b0, rxls_pkg::IDX_STAT_HDLC, 32'h0);
    check(32'h0c, rd & 32'h0c);
    hdlc.fifo_level <= 7'h21;
    bus(1'b0, rxls_pkg::IDX_STAT_HDLC, 32'h0);
    check(32'h03, rd & 32'h03);
    bus(1'b0, rxls_pkg::IDX_STAT_HDLC, 32'h0);
    check(32'h0, rd);
    $display("test hdlc done");
  endtask

  task automatic test_timers();
    bus(1'b0, rxls_pkg::IDX_STAT_FOUR, 32'h0);
    bus(1'b1, rxls_pkg::IDX_CONFIG, 32'h11);
    bus(1'b0, rxls_pkg::IDX_STAT_FOUR, 32'h0);
    check(32'h02, rd & 32'h02);
    bus(1'b0, rxls_pkg::IDX_CONFIG, 32'h0);
    check(32'h01, rd);
    bus(1'b0, rxls_pkg::IDX_STAT_TWO, 32'h0);
    bus(1'b0, rxls_pkg::IDX_STAT_THREE, 32'h0);
    // Longer than one second of the shortened frame timing.
    repeat (170) @(posedge hclk);
    bus(1'b0, rxls_pkg::IDX_STAT_FOUR, 32'h0);
    check(32'h07, rd & 32'h07);
    bus(1'b0, rxls_pkg::IDX_STAT_TWO, 32'h0);
    check(32'h03, rd & 32'h03);
    frm.v52_link_ident <= 1'b1;
    repeat (2) pf('{ts16_valid: 1'b1, ts16_byte: 8'h04, default: '0});
    bus(1'b0, rxls_pkg::IDX_STAT_THREE, 32'h0);
    check(32'h03, rd);
    frm.v52_link_ident <= 1'b0;
    pf('{ts16_valid: 1'b1, default: '0});
    bus(1'b0, rxls_pkg::IDX_STAT_THREE, 32'h0);
    check(32'h30, rd);
    bus(1'b1, rxls_pkg::IDX_CONFIG, 32'h07);
    bus(1'b0, rxls_pkg::IDX_STAT_FOUR, 32'h0);
    bus(1'b0, rxls_pkg::IDX_STAT_TWO, 32'h0);
    pf('{crc_mf_boundary: 1'b1, rx_mf_boundary: 1'b1, default: '0});
    bus(1'b0, rxls_pkg::IDX_STAT_TWO, 32'h0);
    check(32'h02, rd & 32'h02);
    bus(1'b0, rxls_pkg::IDX_STAT_FOUR, 32'h0);
    check(32'h01, rd & 32'h01);
    for (int i = 0; i < 914; i++)
      pf('{crc_word: 1'b1, crc_word_err: 1'b1, default: '0});
    bus(1'b0, rxls_pkg::IDX_STAT_TWO, 32'h0);
    check(32'h0, rd & 32'h40);
    pf('{crc_word: 1'b1, crc_word_err: 1'b1, default: '0});
    bus(1'b0, rxls_pkg::IDX_STAT_TWO, 32'h0);
    check(32'h40, rd & 32'h40);
    $display("test timers done");
  endtask

  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    haddr = 32'h0;
    hwdata = 32'h0;
    frm = '0;
    hdlc = '0;
    clk_run = 1'b1;
    miscompares = 0;
    tests_run = 0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    test_reset();
    test_t1();
    test_e1();
    test_codes();
    test_estore();
    test_hdlc();
    test_timers();
    give_verdict();
  end
endmodule
